// >>> inc/async_mem_seq_consts.vh
// constants shared by the asynchronous memory access sequencer and its request fifo
`ifndef ASYNC_MEM_SEQ_CONSTS_VH
`define ASYNC_MEM_SEQ_CONSTS_VH

// number of asynchronous chip selects
`define NUM_CS 3
// width of every per-chip-select timing field, turnaround included
`define FLD_W 6
// external pin widths
`define EXT_ADDR_W 22
`define BANK_W 2
`define EXT_DATA_W 16
// request side widths
`define REQ_ADDR_W 24
`define WORD_W 32
`define CS_IDX_W 2
// request entry: {write, cs index, address, data}
`define REQ_W 59
`define REQ_WR_BIT 58
`define REQ_CS_LSB 56
`define REQ_ADDR_LSB 32
// request fifo depth and pointer width
`define FIFO_DEPTH 32
`define FIFO_AW 5
// beat counter and last beat for 16-bit and 8-bit devices
`define BEAT_W 2
`define LAST_BEAT_WIDE 2'h1
`define LAST_BEAT_NARROW 2'h3
// byte lane masks, active low
`define BE_WIDE 2'h0
`define BE_NARROW 2'h2
`define BE_OFF 2'h3
// one cycle of turnaround forced on a direction change with a zero field
`define TA_MIN 6'h01
`define CNT_ZERO 6'h00
`define CNT_ONE 6'h01

`endif

// >>> verilog/req_fifo.v
// synchronous first-word-fall-through fifo holding queued memory requests
`timescale 1ns/10ps
`default_nettype none
`include "async_mem_seq_consts.vh"

module req_fifo #(
	parameter WIDTH = `REQ_W,
	parameter DEPTH = `FIFO_DEPTH,
	parameter AW = `FIFO_AW
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// fill side
	input wire inValid,
	output reg inReady,
	input wire [WIDTH-1:0] inData,
	// drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wrPtr;
	reg [AW-1:0] rdPtr;
	reg [AW:0] count;
	wire push;
	wire pop;
	reg [AW:0] next_count;

	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outValid = (count != {(AW+1){1'b0}});
	assign outData = mem[rdPtr];

	// occupancy after this cycle's push and pop
	always @* begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// storage has no reset, it is only read below the count
	always @(posedge mclk) begin
		if (push) begin
			mem[wrPtr] <= inData;
		end
	end

	// ready is registered so the upstream sees a clean flop
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPtr <= {AW{1'b0}};
			rdPtr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
			inReady <= 1'b1;
		end else begin
			if (push) begin
				wrPtr <= wrPtr + 1'b1;
			end
			if (pop) begin
				rdPtr <= rdPtr + 1'b1;
			end
			count <= next_count;
			inReady <= (next_count != DEPTH[AW:0]);
		end
	end

endmodule
`default_nettype wire

// >>> verilog/async_memory_access_sequencer.v
// sequencer running turnaround, setup, strobe and hold cycles to async sram or nor flash
`timescale 1ns/10ps
`default_nettype none
`include "async_mem_seq_consts.vh"

// Overview of operation
// - select-strobe bit set means select-strobe timing; lane masks act as byte enables
// - in select-strobe mode chip select is low only during strobe
// - start only when no higher task pends; wide requests run several beats
// - wait the chip select's turnaround count before setup
// - no turnaround between two reads or between two writes
// - direction change with zero turnaround field still costs one cycle
// - after turnaround recheck priority; abandon before setup if outranked
// - setup start loads setup, strobe, hold from read or write fields
// - select-strobe read drives address, bank and byte enables from setup
// - select-strobe read: select and output enable low through strobe only
// - read data captured on the edge ending strobe
// - memory wait input stretches strobe beyond its programmed count
// - write strobe high during reads, output enable high during writes
// - select-strobe write drives address, data, byte enables from setup
// - select-strobe write: select and write strobe low through strobe only
// - normal write drops write strobe and byte enables when strobe ends
// - hold end drops address and data; select-strobe drops byte enables
// - normal mode releases chip select after hold of the last beat, unless a request to the same select goes straight to setup
// - further beats go hold to setup, no turnaround, counts not reloaded
// - after the request go idle, or straight to the next request's turnaround or setup
// - select-strobe bit clear means normal timing; lane masks are byte enables
// - normal mode: select low from setup through hold
module async_memory_access_sequencer #(
	parameter FIFO_DEPTH = `FIFO_DEPTH,
	parameter FIFO_AW = `FIFO_AW
) (
	// clock and reset
	input wire mclk,
	input wire nrst,
	// request stream
	input wire reqValid,
	output wire reqReady,
	input wire reqWrite,
	input wire [`CS_IDX_W-1:0] reqCs,
	input wire [`REQ_ADDR_W-1:0] reqAddr,
	input wire [`WORD_W-1:0] reqData,
	// arbitration from the rest of the controller
	input wire higherTaskPending,
	// completion
	output reg [`WORD_W-1:0] rdData,
	output reg rdValid,
	output reg wrDone,
	// per chip select configuration, entry i at bits of index i
	input wire [`NUM_CS-1:0] cfgSelStrobe,
	input wire [`NUM_CS-1:0] cfgExtWait,
	input wire [`NUM_CS-1:0] cfgWide,
	input wire [`NUM_CS*`FLD_W-1:0] turnaround_cycles,
	input wire [`NUM_CS*`FLD_W-1:0] cfgRdSetup,
	input wire [`NUM_CS*`FLD_W-1:0] cfgRdStrobe,
	input wire [`NUM_CS*`FLD_W-1:0] cfgRdHold,
	input wire [`NUM_CS*`FLD_W-1:0] cfgWrSetup,
	input wire [`NUM_CS*`FLD_W-1:0] cfgWrStrobe,
	input wire [`NUM_CS*`FLD_W-1:0] cfgWrHold,
	// memory pins
	output reg [`NUM_CS-1:0] async_chip_select_n,
	output reg read_output_enable_n,
	output reg write_strobe_n,
	output reg [1:0] byte_lane_mask_n,
	output reg [`EXT_ADDR_W-1:0] external_address_bus,
	output reg [`BANK_W-1:0] bank_address_bus,
	input wire [`EXT_DATA_W-1:0] external_data_bus_in,
	output reg [`EXT_DATA_W-1:0] external_data_bus_out,
	output reg external_data_bus_oe,
	input wire memory_wait_input
);

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_TURN = 5'h02;
	localparam [4:0] ST_SETUP = 5'h04;
	localparam [4:0] ST_STROBE = 5'h08;
	localparam [4:0] ST_HOLD = 5'h10;

	// field of one chip select out of a packed per-select vector; index 3 gives zero
	function [`FLD_W-1:0] pickFld;
		input [`NUM_CS*`FLD_W-1:0] v;
		input [`CS_IDX_W-1:0] i;
		begin
			pickFld = (i < `NUM_CS) ? v[i*`FLD_W +: `FLD_W] : `CNT_ZERO;
		end
	endfunction

	// flag of one chip select; index 3 selects nothing
	function pickBit;
		input [`NUM_CS-1:0] v;
		input [`CS_IDX_W-1:0] i;
		begin
			pickBit = (i < `NUM_CS) ? v[i] : 1'b0;
		end
	endfunction

	// one-hot chip select line for an index
	function [`NUM_CS-1:0] csHot;
		input [`CS_IDX_W-1:0] i;
		begin
			csHot = (i < `NUM_CS) ? ({{(`NUM_CS-1){1'b0}}, 1'b1} << i) : {`NUM_CS{1'b0}};
		end
	endfunction

	// lanes of the word that one beat carries
	function [`EXT_DATA_W-1:0] laneData;
		input [`WORD_W-1:0] w;
		input [`BEAT_W-1:0] b;
		input wide;
		begin
			if (wide) begin
				laneData = b[0] ? w[31:16] : w[15:0];
			end else begin
				case (b)
					2'h0: laneData = {8'h00, w[7:0]};
					2'h1: laneData = {8'h00, w[15:8]};
					2'h2: laneData = {8'h00, w[23:16]};
					default: laneData = {8'h00, w[31:24]};
				endcase
			end
		end
	endfunction

	// request queue
	wire [`REQ_W-1:0] hEntry;
	wire hValid;
	reg pop;
	wire hWrite = hEntry[`REQ_WR_BIT];
	wire [`CS_IDX_W-1:0] hCs = hEntry[`REQ_WR_BIT-1:`REQ_CS_LSB];

	req_fifo #(
		.WIDTH(`REQ_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_req_fifo (
		.mclk(mclk),
		.nrst(nrst),
		.inValid(reqValid),
		.inReady(reqReady),
		.inData({reqWrite, reqCs, reqAddr, reqData}),
		.outValid(hValid),
		.outReady(pop),
		.outData(hEntry)
	);

	// sequencer state and the request being served
	reg [4:0] state;
	reg [`FLD_W-1:0] cnt;
	reg [`BEAT_W-1:0] beat;
	reg [`REQ_W-1:0] cur;
	reg [`FLD_W-1:0] setupLd;
	reg [`FLD_W-1:0] strobeLd;
	reg [`FLD_W-1:0] holdLd;
	reg lastValid;
	reg lastWrite;
	reg [`WORD_W-1:0] rdWord;
	reg waitMeta;
	reg waitSync;

	reg [4:0] next_state;
	reg [`FLD_W-1:0] next_cnt;
	reg [`BEAT_W-1:0] next_beat;
	reg goSetup;
	reg tryStart;
	reg capture;
	reg done;

	wire curWrite = cur[`REQ_WR_BIT];
	wire [`CS_IDX_W-1:0] curCs = cur[`REQ_WR_BIT-1:`REQ_CS_LSB];
	wire curWide = pickBit(cfgWide, curCs);
	wire [`BEAT_W-1:0] lastBeat = curWide ? `LAST_BEAT_WIDE : `LAST_BEAT_NARROW;
	// a stretched strobe only while extended wait is enabled for this select
	wire stall = pickBit(cfgExtWait, curCs) && waitSync;

	// turnaround owed by the queue head; first access after reset pays the field
	wire [`FLD_W-1:0] hTa = pickFld(turnaround_cycles, hCs);
	wire sameDir = lastValid && (lastWrite == hWrite);
	wire [`FLD_W-1:0] taNeed = sameDir ? `CNT_ZERO :
		((lastValid && hTa == `CNT_ZERO) ? `TA_MIN : hTa);
	wire [`FLD_W-1:0] hSetup = hWrite ? pickFld(cfgWrSetup, hCs) : pickFld(cfgRdSetup, hCs);
	wire [`FLD_W-1:0] hStrobe = hWrite ? pickFld(cfgWrStrobe, hCs) : pickFld(cfgRdStrobe, hCs);
	wire [`FLD_W-1:0] hHold = hWrite ? pickFld(cfgWrHold, hCs) : pickFld(cfgRdHold, hCs);

	// next-state logic; a setup, strobe or hold value n lasts n+1 clocks, a turnaround value n lasts n clocks
	always @* begin
		next_state = state;
		next_cnt = cnt;
		next_beat = beat;
		goSetup = 1'b0;
		tryStart = 1'b0;
		capture = 1'b0;
		done = 1'b0;
		case (state)
			ST_IDLE: begin
				tryStart = 1'b1;
			end
			ST_TURN: begin
				if (cnt != `CNT_ONE) begin
					next_cnt = cnt - 1'b1;
				end else if (higherTaskPending) begin
					next_state = ST_IDLE;
				end else begin
					goSetup = 1'b1;
				end
			end
			ST_SETUP: begin
				if (cnt != `CNT_ZERO) begin
					next_cnt = cnt - 1'b1;
				end else begin
					next_state = ST_STROBE;
					next_cnt = strobeLd;
				end
			end
			ST_STROBE: begin
				if (cnt != `CNT_ZERO) begin
					next_cnt = cnt - 1'b1;
				end else if (!stall) begin
					capture = !curWrite;
					next_state = ST_HOLD;
					next_cnt = holdLd;
				end
			end
			ST_HOLD: begin
				if (cnt != `CNT_ZERO) begin
					next_cnt = cnt - 1'b1;
				end else if (beat != lastBeat) begin
					// beats left on either device width: next beat reuses the loaded counts
					next_beat = beat + 1'b1;
					next_state = ST_SETUP;
					next_cnt = setupLd;
				end else begin
					done = 1'b1;
					next_beat = {`BEAT_W{1'b0}};
					next_state = ST_IDLE;
					tryStart = 1'b1;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_cnt = `CNT_ZERO;
			end
		endcase
		// the head is only taken when nothing outranks it
		if (tryStart && hValid && !higherTaskPending) begin
			if (taNeed == `CNT_ZERO) begin
				goSetup = 1'b1;
			end else begin
				next_state = ST_TURN;
				next_cnt = taNeed;
			end
		end
		pop = goSetup;
		if (goSetup) begin
			next_state = ST_SETUP;
			next_cnt = hSetup;
		end
	end

	// pin values for the coming cycle, from next state and next request
	wire [`REQ_W-1:0] nCur = pop ? hEntry : cur;
	wire nWrite = nCur[`REQ_WR_BIT];
	wire [`CS_IDX_W-1:0] nCs = nCur[`REQ_WR_BIT-1:`REQ_CS_LSB];
	wire nWide = pickBit(cfgWide, nCs);
	wire nSs = pickBit(cfgSelStrobe, nCs);
	wire [`REQ_ADDR_W-1:0] nAddr = nCur[`REQ_WR_BIT-1-`CS_IDX_W:`REQ_ADDR_LSB];
	wire nAct = (next_state == ST_SETUP) || (next_state == ST_STROBE) || (next_state == ST_HOLD);
	wire nStb = (next_state == ST_STROBE);
	// 16-bit devices are addressed in halfwords, 8-bit in bytes
	wire [`REQ_ADDR_W-1:0] nBase = nWide ? {1'b0, nAddr[`REQ_ADDR_W-1:1]} : nAddr;
	wire [`REQ_ADDR_W-1:0] nUnit = nBase + {{(`REQ_ADDR_W-`BEAT_W){1'b0}}, next_beat};
	// select-strobe keeps the lanes for the whole access, normal writes only in strobe
	wire nMaskOn = nSs ? nAct : (nWrite ? nStb : nAct);
	wire [`NUM_CS-1:0] nCsOn = nSs ? {`NUM_CS{nStb}} : {`NUM_CS{nAct}};

	// two flops on the asynchronous wait pin before anything looks at it
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			waitMeta <= 1'b0;
			waitSync <= 1'b0;
		end else begin
			waitMeta <= memory_wait_input;
			waitSync <= waitMeta;
		end
	end

	// sequencer registers, request latch and read assembly
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			cnt <= `CNT_ZERO;
			beat <= {`BEAT_W{1'b0}};
			cur <= {`REQ_W{1'b0}};
			setupLd <= `CNT_ZERO;
			strobeLd <= `CNT_ZERO;
			holdLd <= `CNT_ZERO;
			lastValid <= 1'b0;
			lastWrite <= 1'b0;
			rdWord <= {`WORD_W{1'b0}};
			rdData <= {`WORD_W{1'b0}};
			rdValid <= 1'b0;
			wrDone <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			beat <= next_beat;
			if (pop) begin
				cur <= hEntry;
				setupLd <= hSetup;
				strobeLd <= hStrobe;
				holdLd <= hHold;
				lastValid <= 1'b1;
				lastWrite <= hWrite;
			end
			// sample the bus on the edge that closes the strobe
			if (capture) begin
				if (curWide) begin
					rdWord[{beat[0], 4'h0} +: `EXT_DATA_W] <= external_data_bus_in;
				end else begin
					rdWord[{beat, 3'h0} +: 8] <= external_data_bus_in[7:0];
				end
			end
			rdValid <= done && !curWrite;
			wrDone <= done && curWrite;
			if (done && !curWrite) begin
				rdData <= rdWord;
			end
		end
	end

	// pin register; everything parks inactive outside setup, strobe and hold
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			async_chip_select_n <= {`NUM_CS{1'b1}};
			read_output_enable_n <= 1'b1;
			write_strobe_n <= 1'b1;
			byte_lane_mask_n <= `BE_OFF;
			external_address_bus <= {`EXT_ADDR_W{1'b0}};
			bank_address_bus <= {`BANK_W{1'b0}};
			external_data_bus_out <= {`EXT_DATA_W{1'b0}};
			external_data_bus_oe <= 1'b0;
		end else begin
			async_chip_select_n <= ~(csHot(nCs) & nCsOn);
			read_output_enable_n <= ~(nStb && !nWrite);
			write_strobe_n <= ~(nStb && nWrite);
			if (nMaskOn) begin
				byte_lane_mask_n <= nWide ? `BE_WIDE : `BE_NARROW;
			end else begin
				byte_lane_mask_n <= `BE_OFF;
			end
			if (nAct) begin
				external_address_bus <= nUnit[`EXT_ADDR_W-1:0];
				bank_address_bus <= nUnit[`REQ_ADDR_W-1:`EXT_ADDR_W];
			end else begin
				external_address_bus <= {`EXT_ADDR_W{1'b0}};
				bank_address_bus <= {`BANK_W{1'b0}};
			end
			// write data stands from setup to the end of hold
			if (nAct && nWrite) begin
				external_data_bus_out <= laneData(nCur[`WORD_W-1:0], next_beat, nWide);
				external_data_bus_oe <= 1'b1;
			end else begin
				external_data_bus_out <= {`EXT_DATA_W{1'b0}};
				external_data_bus_oe <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// >>> testbench/async_mem_seq_checker.sv
// assertions on the memory pins of the access sequencer
`timescale 1ns/10ps
`default_nettype none
module async_mem_seq_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// watched ports
	input wire logic [2:0] cfgSelStrobe,
	input wire logic [2:0] async_chip_select_n,
	input wire logic read_output_enable_n,
	input wire logic write_strobe_n,
	input wire logic [1:0] byte_lane_mask_n,
	input wire logic external_data_bus_oe,
	input wire logic rdValid,
	input wire logic wrDone
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// strobe levels, active high for readability
	wire rdStb = !read_output_enable_n;
	wire wrStb = !write_strobe_n;
	wire ssLow = |(cfgSelStrobe & ~async_chip_select_n);

	strobe_excl_a: assert property (!(rdStb && wrStb))
		else $error("read and write strobes low together");
	read_bus_free_a: assert property (rdStb |-> !external_data_bus_oe)
		else $error("data bus driven during read strobe");
	write_data_on_a: assert property (wrStb |-> external_data_bus_oe)
		else $error("write strobe without driven data");
	strobe_select_a: assert property ((rdStb || wrStb) |-> $onehot(~async_chip_select_n))
		else $error("strobe without exactly one select");
	ss_select_a: assert property (ssLow |-> (rdStb || wrStb))
		else $error("select-strobe select low outside strobe");
	lane_enable_a: assert property ((rdStb || wrStb) |-> byte_lane_mask_n != 2'h3)
		else $error("byte enables off during strobe");
	data_release_a: assert property ($fell(external_data_bus_oe) |-> write_strobe_n && $past(write_strobe_n))
		else $error("write data dropped without hold");
	done_pulse_a: assert property ((rdValid || wrDone) |=> !(rdValid || wrDone))
		else $error("completion pulse longer than one cycle");

	// main scenarios reached
	cover property (rdValid);
	cover property (wrDone);
	cover property (ssLow && rdStb);
endmodule

bind async_memory_access_sequencer async_mem_seq_checker checker_inst (
	.mclk, .nrst, .cfgSelStrobe, .async_chip_select_n, .read_output_enable_n,
	.write_strobe_n, .byte_lane_mask_n, .external_data_bus_oe, .rdValid, .wrDone);
`default_nettype wire

// >>> testbench/sram_model.sv
// behavioural async sram answering the sequencer's memory pins
`timescale 1ns/10ps
`default_nettype none
module sram_model (
	// clock and stall length
	input wire logic mclk,
	input wire logic [3:0] stallLen,
	// memory pins
	input wire logic [2:0] csN,
	input wire logic oeN,
	input wire logic weN,
	input wire logic [1:0] maskN,
	input wire logic [21:0] addr,
	input wire logic [15:0] din,
	output logic [15:0] dout,
	output logic waitReq
);
	logic [15:0] mem [0:255];
	logic [15:0] last = 16'h0000;
	logic [3:0] left = 4'h0;
	logic prevSel = 1'b0;
	wire sel = csN != 3'h7;
	// released bus toggles each cycle so a late sample never looks right
	always @* begin
		if (sel && !oeN)
			dout = mem[addr[7:0]];
		else
			dout = ~last;
	end
	// byte lanes written while the write strobe is low
	always @(posedge mclk) begin
		last <= dout;
		if (sel && !weN && !maskN[0])
			mem[addr[7:0]][7:0] <= din[7:0];
		if (sel && !weN && !maskN[1])
			mem[addr[7:0]][15:8] <= din[15:8];
	end
	// wait raised when selected and held for stallLen clocks
	always @(posedge mclk) begin
		prevSel <= sel;
		if (sel && !prevSel)
			left <= stallLen;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	assign waitReq = left != 4'h0;
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// self-checking bench for the async memory access sequencer
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct packed {logic w; logic [1:0] c; logic [23:0] a; logic [31:0] d; logic [7:0] n;} row_t;
	logic mclk, nrst, reqValid, reqWrite, hiPend, rdValid, wrDone, reqReady, oeN, weN, busOe, waitReq;
	logic [1:0] reqCs, maskN, bank;
	logic [23:0] reqAddr;
	logic [31:0] reqData, rdData;
	logic [2:0] csN, ss, ew, wd;
	logic [17:0] ta, rS, rT, rH, wS, wT, wH;
	logic [21:0] addr;
	logic [15:0] dOut, dIn;
	logic [3:0] stallLen;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	int stbCnt = 0;
	int s0, t0, t1, t2, t3, n;
	row_t rows [0:5];

	async_memory_access_sequencer #(.FIFO_DEPTH(4), .FIFO_AW(2)) async_memory_access_sequencer_inst (
		.mclk(mclk), .nrst(nrst), .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite),
		.reqCs(reqCs), .reqAddr(reqAddr), .reqData(reqData), .higherTaskPending(hiPend),
		.rdData(rdData), .rdValid(rdValid), .wrDone(wrDone), .cfgSelStrobe(ss), .cfgExtWait(ew),
		.cfgWide(wd), .turnaround_cycles(ta), .cfgRdSetup(rS), .cfgRdStrobe(rT), .cfgRdHold(rH),
		.cfgWrSetup(wS), .cfgWrStrobe(wT), .cfgWrHold(wH), .async_chip_select_n(csN),
		.read_output_enable_n(oeN), .write_strobe_n(weN), .byte_lane_mask_n(maskN),
		.external_address_bus(addr), .bank_address_bus(bank), .external_data_bus_in(dIn),
		.external_data_bus_out(dOut), .external_data_bus_oe(busOe), .memory_wait_input(waitReq));
	sram_model mem_inst (.mclk(mclk), .stallLen(stallLen), .csN(csN), .oeN(oeN), .weN(weN),
		.maskN(maskN), .addr(addr), .din(dOut), .dout(dIn), .waitReq(waitReq));

	always #5 mclk = ~mclk;
	// strobe cycles seen on the pins, sampled away from the launching edge
	always @(negedge mclk) if (oeN === 1'b0 || weN === 1'b0) stbCnt++;
	// cycle counter with a ceiling that ends a hung run
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			conclude();
		end
	end

	task chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task conclude;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// offer one request and hold it until taken; the caller releases valid
	task push(input logic w, input logic [1:0] c, input logic [23:0] a, input logic [31:0] d);
		reqWrite <= w;
		reqCs <= c;
		reqAddr <= a;
		reqData <= d;
		reqValid <= 1'b1;
		do @(negedge mclk); while (reqReady !== 1'b1);
		@(posedge mclk);
	endtask
	task waitDone(input logic w, output int t);
		int k;
		k = 0;
		do begin
			@(negedge mclk);
			k++;
		end while ((w ? wrDone : rdValid) !== 1'b1 && k < 400);
		chk(k < 400, "no completion");
		t = cyc;
	endtask
	// write then read against read then read; the gap difference is the turnaround
	task gapTest(input logic [1:0] c, input int tx);
		push(1'b1, c, 24'h000100, 32'h01234567);
		push(1'b0, c, 24'h000100, 32'h00000000);
		reqValid <= 1'b0;
		waitDone(1'b1, t0);
		waitDone(1'b0, t1);
		@(posedge mclk);
		push(1'b0, c, 24'h000100, 32'h00000000);
		push(1'b0, c, 24'h000100, 32'h00000000);
		reqValid <= 1'b0;
		waitDone(1'b0, t2);
		waitDone(1'b0, t3);
		chk((t1 - t0) - (t3 - t2) == tx, "turnaround length");
		chk(rdData === 32'h01234567, "gap read data");
		@(posedge mclk);
	endtask

	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		reqValid = 1'b0;
		reqWrite = 1'b0;
		reqCs = 2'h0;
		reqAddr = 24'h000000;
		reqData = 32'h00000000;
		hiPend = 1'b0;
		stallLen = 4'h0;
		// cs0 normal wide, cs1 select-strobe wide, cs2 normal byte-wide
		ss = 3'h2;
		ew = 3'h1;
		wd = 3'h3;
		ta = {6'h00, 6'h03, 6'h00};
		rS = {6'h01, 6'h01, 6'h03};
		wS = {6'h01, 6'h01, 6'h03};
		rT = {3{6'h02}};
		wT = {3{6'h02}};
		rH = {3{6'h01}};
		wH = {3{6'h01}};
		rows = '{{1'b1, 2'h0, 24'h000010, 32'hA5C31234, 8'h06}, {1'b0, 2'h0, 24'h000010, 32'hA5C31234, 8'h06},
			{1'b1, 2'h1, 24'h000040, 32'h0F1E2D3C, 8'h06}, {1'b0, 2'h1, 24'h000040, 32'h0F1E2D3C, 8'h06},
			{1'b1, 2'h2, 24'h000080, 32'h11223344, 8'h0C}, {1'b0, 2'h2, 24'h000080, 32'h11223344, 8'h0C}};
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		chk(csN === 3'h7 && oeN === 1'b1 && weN === 1'b1 && maskN === 2'h3 && busOe === 1'b0
			&& reqReady === 1'b1, "idle after reset");
		@(posedge mclk);
		foreach (rows[i]) begin
			s0 = stbCnt;
			push(rows[i].w, rows[i].c, rows[i].a, rows[i].d);
			reqValid <= 1'b0;
			waitDone(rows[i].w, t0);
			chk(stbCnt - s0 == rows[i].n, "strobe cycles per request");
			if (!rows[i].w)
				chk(rdData === rows[i].d, "read data");
			@(posedge mclk);
		end
		gapTest(2'h0, 1);
		gapTest(2'h1, 3);
		// outranked only once turnaround runs: the write must stop before setup
		s0 = stbCnt;
		push(1'b1, 2'h1, 24'h000200, 32'h5A5A5A5A);
		reqValid <= 1'b0;
		repeat (2) @(posedge mclk);
		hiPend <= 1'b1;
		n = 0;
		repeat (8) begin
			@(negedge mclk);
			if (addr !== 22'h000000 || csN !== 3'h7)
				n++;
		end
		chk(n == 0 && stbCnt == s0, "setup after turnaround while outranked");
		@(posedge mclk);
		hiPend <= 1'b0;
		waitDone(1'b1, t0);
		chk(stbCnt - s0 == 6, "abandoned write not retried");
		@(posedge mclk);
		// outranked: fill the queue until refused, nothing may start
		hiPend <= 1'b1;
		s0 = stbCnt;
		n = 0;
		push(1'b0, 2'h0, 24'h000010, 32'h00000000);
		n = 1;
		repeat (8) begin
			@(negedge mclk);
			if (reqReady === 1'b1)
				n++;
			@(posedge mclk);
		end
		reqValid <= 1'b0;
		chk(n == 4, "queue depth");
		chk(stbCnt == s0, "start while outranked");
		// drain with the memory stalling the first access; the later reads keep the select low, so they are not stalled
		stallLen <= 4'hA;
		hiPend <= 1'b0;
		repeat (4) begin
			waitDone(1'b0, t0);
			chk(rdData === 32'hA5C31234, "drained read");
		end
		chk(stbCnt - s0 > 24, "wait not honoured");
		conclude();
	end
endmodule
`default_nettype wire
